// ---- mfr_deglitch.sv ----
// Deglitch filter: the output follows the input once it has held a new level for len_cycles.
// Input must already be synchronous to sys_clk; len_cycles of zero passes the input with one flop.
`timescale 1ns/1ps
`default_nettype none
`include "mfr_map.svh"
module mfr_deglitch import mfr_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic level_in,
   input wire logic [`MFR_FILTER_CNT_W-1:0] len_cycles,
   output logic level_out
);
   logic [`MFR_FILTER_CNT_W-1:0] cnt_reg;
   logic out_reg;
   wire differs = level_in != out_reg;
   wire [`MFR_FILTER_CNT_W-1:0] cnt_inc = cnt_reg + `MFR_FILTER_CNT_W'h1;
   wire settled = (len_cycles == '0) || (cnt_inc >= len_cycles);

   // Count cycles of disagreement, adopt the new level when it has held long enough
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end else if (!differs) begin
         cnt_reg <= '0;
      end else if (settled) begin
         cnt_reg <= '0;
         out_reg <= level_in;
      end else begin
         cnt_reg <= cnt_inc;
      end
   end

   assign level_out = out_reg;
endmodule : mfr_deglitch
`default_nettype wire

// ---- mfr_fault_ctrl.sv ----
// Fault response block: configuration registers, current-limit lock response with retries,
// supply floor and ceiling faults, and the no-motor current threshold.
// Assumes a 50 MHz sys_clk, a host register port on the same clock, and an asynchronous lock pin.
//
// Behaviour
// - Threshold code selects one of eight currents
// - Codes 0-3 latch fault, pin, driver state
// - Codes 4-7 auto-clear, retries then latch, except retry code 0 retries without limit
// - Code 8 reports lock only, no action
// - Codes 9-F disable lock detection
// - Lock condition filtered 0 to 7 us
// - Floor code sets minimum running supply
// - Undervoltage latches or clears when in bounds
// - Ceiling code sets maximum running supply
// - Overvoltage latches or clears when in bounds
// - Retry code maps to unlimited or 2-20
// - Fault register at 92h, resets zero
`timescale 1ns/1ps
`default_nettype none
`include "mfr_map.svh"
module mfr_fault_ctrl import mfr_pkg::*; #(
   parameter int LOCK_RETRY_CYCLES = `MFR_LOCK_RETRY_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic ilimit_lock_pin,
   input wire logic [`MFR_TAB_VOLT_W-1:0] supply_level,
   input wire logic [`MFR_TAB_CUR_W-1:0] phase_current,
   input wire logic fault_clear,
   output logic fault_output_pin_n,
   output logic gate_override,
   output mfr_gate_t gate_action,
   output mfr_status_t fault_status,
   output logic motor_run_ok,
   output logic [`MFR_TAB_CUR_W-1:0] no_motor_threshold,
   output logic no_motor_below
);
   localparam logic [7:0] OFS_TAB [`MFR_NUM_REGS] = '{`MFR_OFS_FAULT_SETUP_TWO, `MFR_OFS_PIN_SETUP,
      `MFR_OFS_DEVICE_SETUP_ONE, `MFR_OFS_DEVICE_SETUP_TWO, `MFR_OFS_PERIPHERAL_SETUP_ONE,
      `MFR_OFS_GATE_DRIVE_SETUP_ONE, `MFR_OFS_GATE_DRIVE_SETUP_TWO};
   localparam logic [31:0] RST_TAB [`MFR_NUM_REGS] = '{`MFR_RST_FAULT_SETUP_TWO, `MFR_RST_PIN_SETUP,
      `MFR_RST_DEVICE_SETUP_ONE, `MFR_RST_DEVICE_SETUP_TWO, `MFR_RST_PERIPHERAL_SETUP_ONE,
      `MFR_RST_GATE_DRIVE_SETUP_ONE, `MFR_RST_GATE_DRIVE_SETUP_TWO};
   localparam logic [31:0] RETRY_LAST = 32'(LOCK_RETRY_CYCLES - 1);

   logic [31:0] regs_reg [`MFR_NUM_REGS];
   logic [`MFR_NUM_REGS-1:0] hit;
   logic [31:0] rd_terms [`MFR_NUM_REGS];
   logic [31:0] rd_next;
   logic [31:0] rdata_reg;

   // One storage word per register; writes to unlisted offsets match nothing
   genvar gi;
   generate
      for (gi = 0; gi < `MFR_NUM_REGS; gi++) begin : g_reg
         assign hit[gi] = reg_addr == OFS_TAB[gi];
         assign rd_terms[gi] = hit[gi] ? regs_reg[gi] : 32'h00000000;
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               regs_reg[gi] <= RST_TAB[gi];
            end else if (reg_wr && hit[gi]) begin
               regs_reg[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // Read mux: unlisted offsets read zero
   always_comb begin
      rd_next = 32'h00000000;
      for (int i = 0; i < `MFR_NUM_REGS; i++) begin
         rd_next = rd_next | rd_terms[i];
      end
   end

   // Read data is held in a flop, one cycle after the address
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rd_next;
      end
   end
   assign reg_rdata = rdata_reg;

   // Field decode of the fault configuration register
   mfr_cfg_t cfg;
   wire [31:0] fcfg = regs_reg[0];
   assign cfg.no_motor_current_threshold = fcfg[`MFR_NO_MOTOR_THR_RANGE];
   assign cfg.current_limit_lock_action = fcfg[`MFR_LOCK_ACTION_RANGE];
   assign cfg.current_limit_lock_filter_time = fcfg[`MFR_LOCK_FILTER_RANGE];
   assign cfg.supply_floor_level = fcfg[`MFR_FLOOR_RANGE];
   assign cfg.undervoltage_recovery_select = fcfg[`MFR_UV_RECOVERY_BIT];
   assign cfg.supply_ceiling_level = fcfg[`MFR_CEILING_RANGE];
   assign cfg.overvoltage_recovery_select = fcfg[`MFR_OV_RECOVERY_BIT];
   assign cfg.retry_attempt_limit = fcfg[`MFR_RETRY_LIMIT_RANGE];

   // Table lookups
   wire [8*`MFR_TAB_VOLT_W-1:0] floor_tab = `MFR_FLOOR_TABLE;
   wire [8*`MFR_TAB_VOLT_W-1:0] ceil_tab = `MFR_CEILING_TABLE;
   wire [8*`MFR_TAB_CUR_W-1:0] cur_tab = `MFR_CURRENT_TABLE;
   wire [8*`MFR_TAB_RETRY_W-1:0] retry_tab = `MFR_RETRY_TABLE;
   wire [`MFR_TAB_VOLT_W-1:0] floor_lvl = floor_tab[cfg.supply_floor_level*`MFR_TAB_VOLT_W +: `MFR_TAB_VOLT_W];
   wire [`MFR_TAB_VOLT_W-1:0] ceil_lvl = ceil_tab[cfg.supply_ceiling_level*`MFR_TAB_VOLT_W +: `MFR_TAB_VOLT_W];
   wire [`MFR_TAB_RETRY_W-1:0] retry_limit =
      retry_tab[cfg.retry_attempt_limit*`MFR_TAB_RETRY_W +: `MFR_TAB_RETRY_W];

   // No-motor threshold and comparison against the measured phase current
   assign no_motor_threshold =
      cur_tab[cfg.no_motor_current_threshold*`MFR_TAB_CUR_W +: `MFR_TAB_CUR_W];
   assign no_motor_below = phase_current < no_motor_threshold;

   // Two-flop synchroniser on the lock comparator pin
   logic lock_meta_reg;
   logic lock_sync_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lock_meta_reg <= 1'b0;
         lock_sync_reg <= 1'b0;
      end else begin
         lock_meta_reg <= ilimit_lock_pin;
         lock_sync_reg <= lock_meta_reg;
      end
   end

   // Filter length in cycles: code times one microsecond
   wire [`MFR_FILTER_CNT_W-1:0] filter_len =
      `MFR_FILTER_CNT_W'(cfg.current_limit_lock_filter_time * `MFR_FILTER_UNIT_CYCLES);
   logic lock_filtered;
   mfr_deglitch u_deglitch (
      .sys_clk(sys_clk),
      .rst(rst),
      .level_in(lock_sync_reg),
      .len_cycles(filter_len),
      .level_out(lock_filtered)
   );

   // Lock response state, declared ahead of the decode that reads the retry count
   mfr_lock_state_t state_reg;
   mfr_lock_state_t state_next;
   logic [31:0] timer_reg;
   logic [`MFR_TAB_RETRY_W-1:0] retry_cnt_reg;
   mfr_gate_t action_reg;
   logic report_reg;

   // Action decode
   wire act_mode = cfg.current_limit_lock_action <= `MFR_ACTION_LAST_ACTIVE;
   wire report_mode = cfg.current_limit_lock_action == `MFR_ACTION_REPORT;
   wire auto_mode = cfg.current_limit_lock_action[`MFR_ACTION_AUTO_BIT];
   wire lock_seen = lock_filtered && act_mode;
   wire [`MFR_TAB_RETRY_W-1:0] retry_inc = retry_cnt_reg + `MFR_TAB_RETRY_W'h1;
   wire retry_full = (cfg.retry_attempt_limit != `MFR_NO_LIMIT) && (retry_cnt_reg >= retry_limit);

   // Next state of the lock response
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MFR_LK_IDLE: begin
            if (lock_seen) begin
               state_next = (auto_mode && !retry_full) ? MFR_LK_RETRY : MFR_LK_LATCHED;
            end
         end
         MFR_LK_RETRY: begin
            if (timer_reg >= RETRY_LAST) begin
               state_next = MFR_LK_IDLE;
            end
         end
         MFR_LK_LATCHED: begin
            if (fault_clear) begin
               state_next = MFR_LK_IDLE;
            end
         end
         default: state_next = MFR_LK_IDLE;
      endcase
   end

   // Lock state, retry timer, retry count and captured driver action
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= MFR_LK_IDLE;
         timer_reg <= 32'h00000000;
         retry_cnt_reg <= '0;
         action_reg <= MFR_GATE_TRISTATE;
      end else begin
         state_reg <= state_next;
         timer_reg <= (state_reg == MFR_LK_RETRY) ? timer_reg + 32'h00000001 : 32'h00000000;
         if (state_reg == MFR_LK_IDLE && lock_seen) begin
            action_reg <= mfr_gate_t'(cfg.current_limit_lock_action[1:0]);
         end
         if (state_reg == MFR_LK_RETRY && state_next == MFR_LK_IDLE) begin
            retry_cnt_reg <= (retry_inc == '0) ? retry_cnt_reg : retry_inc;
         end else if (fault_clear && state_reg != MFR_LK_RETRY) begin
            retry_cnt_reg <= '0;
         end
      end
   end

   // Report-only flag: sticky, the set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         report_reg <= 1'b0;
      end else if (lock_filtered && report_mode) begin
         report_reg <= 1'b1;
      end else if (fault_clear) begin
         report_reg <= 1'b0;
      end
   end

   // Supply bounds; code zero means no limit
   wire under = (cfg.supply_floor_level != `MFR_NO_LIMIT) && (supply_level < floor_lvl);
   wire over = (cfg.supply_ceiling_level != `MFR_NO_LIMIT) && (supply_level > ceil_lvl);
   logic uv_reg;
   logic ov_reg;

   // Supply faults: set wins; clear by itself or by fault_clear once back in bounds
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         uv_reg <= 1'b0;
         ov_reg <= 1'b0;
      end else begin
         if (under) begin
            uv_reg <= 1'b1;
         end else if (cfg.undervoltage_recovery_select || fault_clear) begin
            uv_reg <= 1'b0;
         end
         if (over) begin
            ov_reg <= 1'b1;
         end else if (cfg.overvoltage_recovery_select || fault_clear) begin
            ov_reg <= 1'b0;
         end
      end
   end

   // Outputs
   wire lock_fault = state_reg != MFR_LK_IDLE;
   assign gate_override = lock_fault;
   assign gate_action = action_reg;
   assign fault_output_pin_n = !(lock_fault || uv_reg || ov_reg);
   assign motor_run_ok = !(lock_fault || uv_reg || ov_reg);
   assign fault_status.lock_fault = lock_fault;
   assign fault_status.lock_reported = report_reg;
   assign fault_status.undervoltage = uv_reg;
   assign fault_status.overvoltage = ov_reg;
endmodule : mfr_fault_ctrl
`default_nettype wire

// ---- mfr_fault_ctrl_asserts.sv ----
// Checker for mfr_fault_ctrl: supply flags, lock response, threshold decode.
// Sees the top ports only; mirrors the fault register from host writes.
`timescale 1ns/1ps
`default_nettype none
`include "mfr_map.svh"
module mfr_chk import mfr_pkg::*; #(
   parameter int LOCK_RETRY_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [8:0] supply_level,
   input wire logic [5:0] phase_current,
   input wire logic fault_clear,
   input wire logic fault_output_pin_n,
   input wire logic gate_override,
   input wire mfr_gate_t gate_action,
   input wire mfr_status_t fault_status,
   input wire logic [5:0] no_motor_threshold,
   input wire logic no_motor_below
);
   localparam logic [71:0] FLT = `MFR_FLOOR_TABLE;
   localparam logic [71:0] CLT = `MFR_CEILING_TABLE;
   localparam logic [47:0] CUT = `MFR_CURRENT_TABLE;
   logic [31:0] cfg_reg;
   // Limits decoded from the mirrored register
   wire [2:0] flc = cfg_reg[10:8];
   wire [2:0] clc = cfg_reg[6:4];
   wire [3:0] act = cfg_reg[18:15];
   wire under = flc != 3'h0 && supply_level < FLT[flc*9 +: 9];
   wire over = clc != 3'h0 && supply_level > CLT[clc*9 +: 9];
   wire [5:0] thv = CUT[cfg_reg[21:19]*6 +: 6];
   // Mirror of the fault register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_reg <= 32'h0;
      end else if (reg_wr && reg_addr == 8'h92) begin
         cfg_reg <= reg_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_UV_SET: assert property (under |=> fault_status.undervoltage) else $error("uv missing");
   AST_OV_SET: assert property (over |=> fault_status.overvoltage) else $error("ov missing");
   AST_UV_AUTO: assert property (cfg_reg[7] && !under |=> !fault_status.undervoltage) else $error("uv kept");
   AST_UV_HOLD: assert property (!cfg_reg[7] && fault_status.undervoltage && !fault_clear
      |=> fault_status.undervoltage) else $error("uv lost");
   AST_PIN: assert property (fault_status[1:0] != 2'h0 || gate_override |-> !fault_output_pin_n)
      else $error("pin idle");
   AST_LATCH: assert property (act < 4'h4 && gate_override && !fault_clear
      |=> gate_override && $stable(gate_action)) else $error("latch lost");
   AST_CODE: assert property (gate_override && act < 4'h8 |-> gate_action == act[1:0]) else $error("state");
   AST_IDLE: assert property (act > 4'h7 && !gate_override |=> !gate_override) else $error("acted");
   AST_THR: assert property (no_motor_threshold == thv && no_motor_below == (phase_current < thv))
      else $error("threshold");
endmodule : mfr_chk
bind mfr_fault_ctrl mfr_chk #(.LOCK_RETRY_CYCLES(LOCK_RETRY_CYCLES)) chk_u (.sys_clk, .rst, .reg_wr, .reg_addr,
   .reg_wdata, .supply_level, .phase_current, .fault_clear, .fault_output_pin_n, .gate_override, .gate_action,
   .fault_status, .no_motor_threshold, .no_motor_below);
`default_nettype wire

// ---- mfr_host.sv ----
// Host model for the register port of the fault block.
// Drives after the falling edge; read data is taken one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module mfr_host import mfr_pkg::*; (
   input wire logic sys_clk,
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
   end
   // Whole-word write; reserved offsets are left alone
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      if (!(a inside {8'h92, 8'ha4, 8'ha6, 8'ha8, 8'haa, 8'hac, 8'hae})) return;
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
endmodule : mfr_host
`default_nettype wire

// ---- mfr_map.svh ----
// Register offsets, reset values, field positions, level tables and timing for the fault response block.
// Assumes a 50 MHz system clock and byte offsets as the host sees them on the register port.
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH

// Register offsets
`define MFR_OFS_FAULT_SETUP_TWO 8'h92
`define MFR_OFS_PIN_SETUP 8'ha4
`define MFR_OFS_DEVICE_SETUP_ONE 8'ha6
`define MFR_OFS_DEVICE_SETUP_TWO 8'ha8
`define MFR_OFS_PERIPHERAL_SETUP_ONE 8'haa
`define MFR_OFS_GATE_DRIVE_SETUP_ONE 8'hac
`define MFR_OFS_GATE_DRIVE_SETUP_TWO 8'hae
`define MFR_NUM_REGS 7

// Reset values
`define MFR_RST_FAULT_SETUP_TWO 32'h00000000
`define MFR_RST_PIN_SETUP 32'h00000000
`define MFR_RST_DEVICE_SETUP_ONE 32'h00000000
`define MFR_RST_DEVICE_SETUP_TWO 32'h00000000
`define MFR_RST_PERIPHERAL_SETUP_ONE 32'h40000000
`define MFR_RST_GATE_DRIVE_SETUP_ONE 32'h10228100
`define MFR_RST_GATE_DRIVE_SETUP_TWO 32'h01200000

// Field positions inside fault_setup_two
`define MFR_NO_MOTOR_THR_RANGE 21:19
`define MFR_LOCK_ACTION_RANGE 18:15
`define MFR_LOCK_FILTER_RANGE 14:12
`define MFR_FLOOR_RANGE 10:8
`define MFR_UV_RECOVERY_BIT 7
`define MFR_CEILING_RANGE 6:4
`define MFR_OV_RECOVERY_BIT 3
`define MFR_RETRY_LIMIT_RANGE 2:0

// Lock action codes
`define MFR_ACTION_AUTO_BIT 2
`define MFR_ACTION_REPORT 4'h8
`define MFR_ACTION_LAST_ACTIVE 4'h7

// Level tables, entry 0 in the low bits; supply in 0.1 V, current in 1/64 A
`define MFR_TAB_VOLT_W 9
`define MFR_TAB_CUR_W 6
`define MFR_TAB_RETRY_W 5
`define MFR_FLOOR_TABLE {9'h07d, 9'h064, 9'h04b, 9'h03c, 9'h037, 9'h032, 9'h02d, 9'h000}
`define MFR_CEILING_TABLE {9'h15e, 9'h145, 9'h12c, 9'h113, 9'h0fa, 9'h0e1, 9'h0c8, 9'h000}
`define MFR_CURRENT_TABLE {6'h28, 6'h1e, 6'h14, 6'h0a, 6'h05, 6'h04, 6'h03, 6'h02}
`define MFR_RETRY_TABLE {5'h14, 5'h0f, 5'h0a, 5'h07, 5'h05, 5'h03, 5'h02, 5'h00}
`define MFR_NO_LIMIT 3'h0

// Timing
`define MFR_CLK_PERIOD_NS 20
`define MFR_FILTER_UNIT_NS 1000
`define MFR_FILTER_UNIT_CYCLES (`MFR_FILTER_UNIT_NS / `MFR_CLK_PERIOD_NS)
`define MFR_FILTER_CNT_W 9
`define MFR_LOCK_RETRY_MS 100
`define MFR_LOCK_RETRY_CYCLES (`MFR_LOCK_RETRY_MS * 1000000 / `MFR_CLK_PERIOD_NS)

`endif

// ---- mfr_pkg.sv ----
// Types shared by the fault response block: decoded configuration, gate actions, lock states.
// Field positions and values live in mfr_map.svh.
package mfr_pkg;

   // Protective gate driver states, in action code order
   typedef enum logic [1:0] {
      MFR_GATE_TRISTATE,
      MFR_GATE_RECIRC,
      MFR_GATE_HS_BRAKE,
      MFR_GATE_LS_BRAKE
   } mfr_gate_t;

   // Lock response states
   typedef enum logic [1:0] {
      MFR_LK_IDLE,
      MFR_LK_RETRY,
      MFR_LK_LATCHED
   } mfr_lock_state_t;

   // Fields of the fault configuration register
   typedef struct packed {
      logic [2:0] no_motor_current_threshold;
      logic [3:0] current_limit_lock_action;
      logic [2:0] current_limit_lock_filter_time;
      logic [2:0] supply_floor_level;
      logic undervoltage_recovery_select;
      logic [2:0] supply_ceiling_level;
      logic overvoltage_recovery_select;
      logic [2:0] retry_attempt_limit;
   } mfr_cfg_t;

   // Fault status seen by the rest of the device
   typedef struct packed {
      logic lock_fault;
      logic lock_reported;
      logic undervoltage;
      logic overvoltage;
   } mfr_status_t;

endpackage : mfr_pkg

// ---- tb.sv ----
// Testbench for mfr_fault_ctrl: registers, threshold, lock response, retries, supply limits.
// Host model drives the register port; all else changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb import mfr_pkg::*;;
   localparam int RC = 20;
   logic sys_clk, rst, reg_wr, ilimit_lock_pin, fault_clear, fault_output_pin_n, gate_override;
   logic motor_run_ok, no_motor_below;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [8:0] supply_level;
   logic [5:0] phase_current, no_motor_threshold;
   mfr_gate_t gate_action;
   mfr_status_t fault_status;
   int failures = 0, checks_done = 0, ticks = 0;
   int rt[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
   mfr_fault_ctrl #(.LOCK_RETRY_CYCLES(RC)) dut_u (.sys_clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .ilimit_lock_pin, .supply_level, .phase_current, .fault_clear, .fault_output_pin_n, .gate_override,
      .gate_action, .fault_status, .motor_run_ok, .no_motor_threshold, .no_motor_below);
   mfr_host host_u (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
   // Clock and hang watchdog
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      ticks++;
      if (ticks == 40000) begin
         failures++;
         finish_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task clr;
      fault_clear = 1'b1;
      cyc(1);
      fault_clear = 1'b0;
      cyc(1);
   endtask : clr
   function logic [31:0] cfg(input int thr, act, flt, fl, uvr, cl, ovr, r);
      return 32'(thr << 19 | act << 15 | flt << 12 | fl << 8 | uvr << 7 | cl << 4 | ovr << 3 | r);
   endfunction : cfg
   // Raise the lock pin and count cycles until protection shows
   task lock_on(output int n);
      ilimit_lock_pin = 1'b1;
      n = 0;
      while (gate_override !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
   endtask : lock_on
   task automatic t_regs;
      logic [7:0] a[8] = '{8'h92, 8'ha4, 8'ha6, 8'ha8, 8'haa, 8'hac, 8'hae, 8'h94};
      logic [31:0] r[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h40000000, 32'h10228100, 32'h01200000, 32'h0};
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         host_u.rd(a[i], d);
         chk(d, r[i]);
         host_u.wr(a[i], 32'h5a5a0000 | a[i]);
         host_u.rd(a[i], d);
         chk(d, i < 7 ? 32'h5a5a0000 | a[i] : 32'h0);
      end
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      host_u.rd(8'h92, d);
      chk(d, 32'h0);
   endtask : t_regs
   task automatic t_thr;
      int t[8] = '{2, 3, 4, 5, 10, 20, 30, 40};
      for (int c = 0; c < 8; c++) begin
         host_u.wr(8'h92, cfg(c, 9, 0, 0, 0, 0, 0, 0));
         for (int k = 0; k < 2; k++) begin
            phase_current = 6'(t[c] - 1 + k);
            cyc(1);
            chk({no_motor_threshold, no_motor_below}, {6'(t[c]), k == 0});
         end
      end
   endtask : t_thr
   task automatic t_lock;
      int n;
      int a;
      for (int i = 0; i < 12; i++) begin
         a = i < 4 ? i : i + 4;
         host_u.wr(8'h92, cfg(0, a, 0, 0, 0, 0, 0, 0));
         lock_on(n);
         chk(n, a < 4 ? 4 : 400);
         chk({gate_override, fault_output_pin_n, fault_status[3:2]}, a < 4 ? 4'ha : {3'h2, a == 8});
         if (a < 4) chk(gate_action, a);
         ilimit_lock_pin = 1'b0;
         cyc(3 * RC);
         chk(gate_override, a < 4);
         clr();
      end
      // A pulse shorter than the 3 us filter is ignored
      host_u.wr(8'h92, cfg(0, 0, 3, 0, 0, 0, 0, 0));
      ilimit_lock_pin = 1'b1;
      cyc(140);
      ilimit_lock_pin = 1'b0;
      cyc(10);
      chk(gate_override, 0);
      lock_on(n);
      chk(n > 149 && n < 157, 1);
      ilimit_lock_pin = 1'b0;
      cyc(160);
      clr();
   endtask : t_lock
   // Pin held high: count drops of protection until it latches; with retry code 0 it must stay unlatched for 600 cycles
   task automatic t_retry;
      int n, h, drops;
      for (int r = 0; r < 8; r++) begin
         host_u.wr(8'h92, cfg(0, 4 + r % 4, 0, 0, 0, 0, 0, r));
         lock_on(n);
         n = 0;
         h = 0;
         drops = 0;
         while (h < RC + 10 && n < 600) begin
            cyc(1);
            n++;
            if (gate_override === 1'b1) begin
               h++;
            end else begin
               if (h > 0) drops++;
               h = 0;
            end
         end
         chk(r == 0 ? n : drops, r == 0 ? 600 : rt[r]);
         chk({gate_action, fault_output_pin_n}, {2'(r % 4), 1'b0});
         ilimit_lock_pin = 1'b0;
         cyc(RC + 10);
         clr();
      end
   endtask : t_retry
   task automatic t_supply;
      int fl[8] = '{0, 45, 50, 55, 60, 75, 100, 125};
      for (int c = 1; c < 8; c++) begin
         host_u.wr(8'h92, cfg(0, 9, 0, c, 1, c, 1, 0));
         for (int k = 0; k < 4; k++) begin
            supply_level = 9'(k < 2 ? fl[c] - 1 + k : 176 + 25 * c - k + 2);
            cyc(2);
            chk(fault_status[1:0], k == 0 ? 2 : k == 2);
            chk(motor_run_ok, k % 2);
         end
      end
      // Back in bounds before latch mode, so the last ceiling step leaves nothing latched
      supply_level = 9'h096;
      cyc(2);
      host_u.wr(8'h92, cfg(0, 9, 0, 1, 0, 1, 0, 0));
      for (int k = 0; k < 2; k++) begin
         supply_level = k ? 9'h0c9 : 9'h02c;
         cyc(2);
         supply_level = 9'h096;
         cyc(3);
         chk(fault_status[1:0], k ? 1 : 2);
         clr();
         chk(fault_status[1:0], 0);
      end
      host_u.wr(8'h92, 32'h0);
      supply_level = 9'h000;
      cyc(2);
      chk(fault_status[1:0], 0);
   endtask : t_supply
   task finish_test;
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      rst = 1'b1;
      ilimit_lock_pin = 1'b0;
      fault_clear = 1'b0;
      supply_level = 9'h096;
      phase_current = 6'h00;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_regs();
      t_thr();
      t_lock();
      t_retry();
      t_supply();
      finish_test();
   end
endmodule : tb
`default_nettype wire
